// *** hw/afecp_core.sv ***
// Front-end control registers, interrupt flag and PWM summing path
`include "afecp_regs.svh"

// What this block does
// - Writing 0x14 to reset register reinitialises
// - Writing 0x03 to bias_zc_enable_reg turns bias on
// - Band bit: 1 selects B/C/D, 0 selects A
// - Writing 0x00 to interrupt_control_reg clears pending interrupts
// - Zero-cross bit in bias_zc_enable_reg enables zero-crossing
// - Transmit gain code 0..3 gives 0.25..1 V/V
// - Receive gain code 0..15 gives 0.25..128 V/V
// - TX and PA set, DAC clear: PWM mode
module afecp_core (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  input wire logic dacModeSel,
  input wire logic shutdownPin,
  input wire logic pwmHigh,
  input wire logic pwmLow,
  input wire logic thermalOverload,
  output logic [1:0] txSum,
  output logic txPathOn,
  output logic paOn,
  output logic dacOn,
  output logic [1:0] biasOn,
  output logic zeroCrossOn,
  output afecp_pkg::afecp_band_t bandSelect,
  output afecp_pkg::afecp_txg_t txGain,
  output logic [8:0] txGainQ8,
  output logic [3:0] rxGain,
  output logic thermalPending,
  output logic thermalIntEn,
  output logic intN
);
  import afecp_pkg::*;

  afecp_frame_if frame ();

  logic [1:0] dacSync_reg;
  logic [1:0] sdSync_reg;
  logic [1:0] pwmHiSync_reg;
  logic [1:0] pwmLoSync_reg;
  logic [1:0] thermSync_reg;
  logic [2:0] enable1_reg;
  logic [1:0] txg_reg;
  logic [3:0] rxg_reg;
  logic [1:0] bias_reg;
  logic zc_reg;
  logic band_reg;
  logic thermEn_reg;
  logic thermPend_reg;
  logic [1:0] sum_reg;
  logic intN_reg;
  logic [8:0] gainQ8_reg;
  logic softReset;
  logic wrEnable1;
  logic wrGain;
  logic wrEnable2;
  logic wrControl1;
  logic wrControl2;
  logic pwmMode;

  afecp_spi_rx rx (
    .clk(clk),
    .nrst(nrst),
    .sclk(sclk),
    .csN(csN),
    .mosi(mosi),
    .frame(frame)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dacSync_reg <= 2'h0;
      sdSync_reg <= 2'h0;
      pwmHiSync_reg <= 2'h0;
      pwmLoSync_reg <= 2'h0;
      thermSync_reg <= 2'h0;
    end else begin
      dacSync_reg <= {dacSync_reg[0], dacModeSel};
      sdSync_reg <= {sdSync_reg[0], shutdownPin};
      pwmHiSync_reg <= {pwmHiSync_reg[0], pwmHigh};
      pwmLoSync_reg <= {pwmLoSync_reg[0], pwmLow};
      thermSync_reg <= {thermSync_reg[0], thermalOverload};
    end
  end

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  assign softReset = frame.valid && frame.addr == `AFECP_ADDR_RESET
    && frame.data == `AFECP_SOFT_RESET_KEY;
  assign wrEnable1 = frame.valid && frame.addr == `AFECP_ADDR_ENABLE1;
  assign wrGain = frame.valid && frame.addr == `AFECP_ADDR_GAIN;
  assign wrEnable2 = frame.valid && frame.addr == `AFECP_ADDR_BIAS_ZC_ENABLE_REG;
  assign wrControl1 = frame.valid && frame.addr == `AFECP_ADDR_BAND_CONTROL_REG;
  assign wrControl2 = frame.valid && frame.addr == `AFECP_ADDR_INTERRUPT_CONTROL_REG;

  // ----------------------------------------------------------------
  // Transmit enable register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst || softReset) begin
      enable1_reg <= `AFECP_RST_ENABLE1;
    end else if (wrEnable1) begin
      enable1_reg <= frame.data[`AFECP_DAC_BIT:`AFECP_PA_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Gain select register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst || softReset) begin
      txg_reg <= `AFECP_RST_TXG;
      rxg_reg <= `AFECP_RST_RXG;
    end else if (wrGain) begin
      txg_reg <= frame.data[`AFECP_TXG_HI:`AFECP_TXG_LO];
      rxg_reg <= frame.data[`AFECP_RXG_HI:`AFECP_RXG_LO];
    end
  end

  // Transmit gain as a fixed-point figure
  always_ff @(posedge clk) begin
    if (!nrst) begin
      gainQ8_reg <= `AFECP_TXG_Q8_0;
    end else begin
      unique case (afecp_txg_t'(txg_reg))
        AFECP_TXG_QUARTER: gainQ8_reg <= `AFECP_TXG_Q8_0;
        AFECP_TXG_HALF: gainQ8_reg <= `AFECP_TXG_Q8_1;
        AFECP_TXG_ROOT_HALF: gainQ8_reg <= `AFECP_TXG_Q8_2;
        AFECP_TXG_UNITY: gainQ8_reg <= `AFECP_TXG_Q8_3;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bias and zero-cross register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst || softReset) begin
      bias_reg <= `AFECP_RST_BIAS;
      zc_reg <= 1'b0;
    end else if (wrEnable2) begin
      bias_reg <= frame.data[`AFECP_BIAS_HI:`AFECP_BIAS_LO];
      zc_reg <= frame.data[`AFECP_ZC_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Band control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst || softReset) begin
      band_reg <= `AFECP_RST_BAND;
    end else if (wrControl1) begin
      band_reg <= frame.data[`AFECP_BAND_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt control: any write clears, a new event still wins
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst || softReset) begin
      thermEn_reg <= 1'b0;
    end else if (wrControl2) begin
      thermEn_reg <= frame.data[`AFECP_THERM_EN_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst || softReset) begin
      thermPend_reg <= 1'b0;
    end else if (thermSync_reg[1]) begin
      thermPend_reg <= 1'b1;
    end else if (wrControl2) begin
      thermPend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      intN_reg <= 1'b1;
    end else begin
      intN_reg <= !(thermPend_reg && thermEn_reg);
    end
  end

  // ----------------------------------------------------------------
  // PWM summing path: live only in PWM mode and out of shutdown
  // ----------------------------------------------------------------
  assign pwmMode = enable1_reg[`AFECP_TX_BIT] && enable1_reg[`AFECP_PA_BIT]
    && !enable1_reg[`AFECP_DAC_BIT] && !dacSync_reg[1]
    && !sdSync_reg[1];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sum_reg <= 2'h0;
    end else if (pwmMode) begin
      sum_reg <= {1'b0, pwmHiSync_reg[1]}
        + {1'b0, pwmLoSync_reg[1]};
    end else begin
      sum_reg <= 2'h0;
    end
  end

  assign txSum = sum_reg;
  assign txPathOn = enable1_reg[`AFECP_TX_BIT];
  assign paOn = enable1_reg[`AFECP_PA_BIT];
  assign dacOn = enable1_reg[`AFECP_DAC_BIT];
  assign biasOn = bias_reg;
  assign zeroCrossOn = zc_reg;
  assign bandSelect = afecp_band_t'(band_reg);
  assign txGain = afecp_txg_t'(txg_reg);
  assign txGainQ8 = gainQ8_reg;
  assign rxGain = rxg_reg;
  assign thermalPending = thermPend_reg;
  assign thermalIntEn = thermEn_reg;
  assign intN = intN_reg;
endmodule

// *** hw/afecp_regs.svh ***
// Register offsets, field positions, reset values and constants
`ifndef AFECP_REGS_SVH
`define AFECP_REGS_SVH

// Frame layout: [15] read flag, [14:8] address, [7:0] data
`define AFECP_FRAME_BITS 16
`define AFECP_FRAME_RD_BIT 15
`define AFECP_ADDR_HI 14
`define AFECP_ADDR_LO 8
`define AFECP_DATA_HI 7
`define AFECP_DATA_LO 0

// Register addresses
`define AFECP_ADDR_ENABLE1 7'h01
`define AFECP_ADDR_GAIN 7'h02
`define AFECP_ADDR_BIAS_ZC_ENABLE_REG 7'h03
`define AFECP_ADDR_BAND_CONTROL_REG 7'h04
`define AFECP_ADDR_INTERRUPT_CONTROL_REG 7'h05
`define AFECP_ADDR_RESET 7'h09

// Soft reset key
`define AFECP_SOFT_RESET_KEY 8'h14

// Transmit enable register fields
`define AFECP_PA_BIT 0
`define AFECP_TX_BIT 1
`define AFECP_DAC_BIT 2

// Gain register fields
`define AFECP_TXG_HI 1
`define AFECP_TXG_LO 0
`define AFECP_RXG_HI 5
`define AFECP_RXG_LO 2

// Bias and zero-cross register fields
`define AFECP_BIAS_HI 1
`define AFECP_BIAS_LO 0
`define AFECP_ZC_BIT 2

// Band and interrupt control fields
`define AFECP_BAND_BIT 0
`define AFECP_THERM_EN_BIT 0

// Reset values
`define AFECP_RST_ENABLE1 3'h0
`define AFECP_RST_TXG 2'h0
`define AFECP_RST_RXG 4'h0
`define AFECP_RST_BIAS 2'h0
`define AFECP_RST_BAND 1'b0

// Transmit gain in units of 1/256 V/V
`define AFECP_TXG_Q8_0 9'h040
`define AFECP_TXG_Q8_1 9'h080
`define AFECP_TXG_Q8_2 9'h0b5
`define AFECP_TXG_Q8_3 9'h100

`endif

// *** hw/afecp_pkg.sv ***
// Types shared by the front-end register logic
package afecp_pkg;
  typedef logic [6:0] afecp_addr_t;
  typedef logic [7:0] afecp_data_t;
  typedef enum logic [1:0] {
    AFECP_TXG_QUARTER,
    AFECP_TXG_HALF,
    AFECP_TXG_ROOT_HALF,
    AFECP_TXG_UNITY
  } afecp_txg_t;
  typedef enum logic {
    AFECP_BAND_A,
    AFECP_BAND_BCD
  } afecp_band_t;
endpackage

// *** hw/afecp_frame_if.sv ***
// Received write frame carried from the serial receiver to the core
interface afecp_frame_if;
  import afecp_pkg::*;
  logic valid;
  afecp_addr_t addr;
  afecp_data_t data;
  modport rx (output valid, output addr, output data);
  modport core (input valid, input addr, input data);
endinterface

// *** hw/afecp_spi_rx.sv ***
// Serial frame receiver: synchronises pins and assembles 16-bit frames
`include "afecp_regs.svh"
module afecp_spi_rx (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  afecp_frame_if.rx frame
);
  import afecp_pkg::*;

  logic [1:0] sclkSync_reg;
  logic [1:0] csNSync_reg;
  logic [1:0] mosiSync_reg;
  logic sclkLast_reg;
  logic csNLast_reg;
  logic [15:0] shift_reg;
  logic [4:0] count_reg;
  logic valid_reg;
  afecp_addr_t addr_reg;
  afecp_data_t data_reg;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sclkSync_reg <= 2'h0;
      csNSync_reg <= 2'h3;
      mosiSync_reg <= 2'h0;
      sclkLast_reg <= 1'b0;
      csNLast_reg <= 1'b1;
    end else begin
      sclkSync_reg <= {sclkSync_reg[0], sclk};
      csNSync_reg <= {csNSync_reg[0], csN};
      mosiSync_reg <= {mosiSync_reg[0], mosi};
      sclkLast_reg <= sclkSync_reg[1];
      csNLast_reg <= csNSync_reg[1];
    end
  end

  // ----------------------------------------------------------------
  // Shift on rising clock while selected
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      shift_reg <= 16'h0000;
      count_reg <= 5'h00;
    end else if (csNSync_reg[1]) begin
      count_reg <= 5'h00;
    end else if (sclkSync_reg[1] && !sclkLast_reg) begin
      shift_reg <= {shift_reg[14:0], mosiSync_reg[1]};
      if (count_reg != 5'h1f) begin
        count_reg <= count_reg + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame ends on deselect; only whole 16-bit write frames count
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      valid_reg <= 1'b0;
      addr_reg <= 7'h00;
      data_reg <= 8'h00;
    end else begin
      valid_reg <= csNSync_reg[1] && !csNLast_reg
        && count_reg == 5'(`AFECP_FRAME_BITS)
        && !shift_reg[`AFECP_FRAME_RD_BIT];
      addr_reg <= shift_reg[`AFECP_ADDR_HI:`AFECP_ADDR_LO];
      data_reg <= shift_reg[`AFECP_DATA_HI:`AFECP_DATA_LO];
    end
  end

  assign frame.valid = valid_reg;
  assign frame.addr = addr_reg;
  assign frame.data = data_reg;
endmodule

// *** sim/afecp_props.sv ***
// Port-level checks for the front-end core
module afecp_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic csN,
  input wire logic shutdownPin,
  input wire logic pwmHigh,
  input wire logic pwmLow,
  input wire logic thermalOverload,
  input wire logic [1:0] txSum,
  input wire logic txPathOn,
  input wire logic paOn,
  input wire logic dacOn,
  input wire logic [1:0] biasOn,
  input wire logic zeroCrossOn,
  input wire afecp_pkg::afecp_band_t bandSelect,
  input wire afecp_pkg::afecp_txg_t txGain,
  input wire logic [8:0] txGainQ8,
  input wire logic [3:0] rxGain,
  input wire logic thermalPending,
  input wire logic thermalIntEn,
  input wire logic intN
);
  import afecp_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  function automatic logic [8:0] gainQ8(input logic [1:0] g);
    case (g)
      2'h0: return 9'h040;
      2'h1: return 9'h080;
      2'h2: return 9'h0b5;
      default: return 9'h100;
    endcase
  endfunction
  AST_INT_LEVEL: assert property (
    intN == !$past(thermalPending && thermalIntEn))
    else $error("interrupt level wrong");
  AST_GAIN_Q8: assert property (
    txGainQ8 == gainQ8($past(txGain)))
    else $error("scaled gain wrong");
  AST_SUM_GATE: assert property (
    txSum != 2'h0 |-> $past(txPathOn && paOn && !dacOn))
    else $error("sum active outside pwm mode");
  AST_SUM_BOTH: assert property (
    txSum == 2'h2 |-> $past(pwmHigh, 3) && $past(pwmLow, 3))
    else $error("sum of two without both inputs");
  AST_SHUTDOWN_QUIET: assert property (
    shutdownPin [*5] |-> txSum == 2'h0)
    else $error("sum active in shutdown");
  AST_THERM_SET: assert property (
    thermalOverload [*2] |-> ##[1:4] thermalPending)
    else $error("thermal flag not set");
  AST_THERM_STICKY: assert property (
    !csN [*5] |-> !$fell(thermalPending))
    else $error("thermal flag dropped without write");
  AST_REGS_HOLD: assert property (
    !csN [*5] |-> $stable({txGain, rxGain, bandSelect, biasOn,
      zeroCrossOn, txPathOn, paOn, dacOn, thermalIntEn}))
    else $error("register moved inside frame");
  cover property (!intN);
  cover property (txSum == 2'h2);
  cover property ($fell(thermalPending));
endmodule

bind afecp_core afecp_props afecp_props_inst (
  .clk(clk), .nrst(nrst), .csN(csN), .shutdownPin(shutdownPin),
  .pwmHigh(pwmHigh), .pwmLow(pwmLow), .thermalOverload(thermalOverload),
  .txSum(txSum), .txPathOn(txPathOn), .paOn(paOn), .dacOn(dacOn),
  .biasOn(biasOn), .zeroCrossOn(zeroCrossOn), .bandSelect(bandSelect),
  .txGain(txGain), .txGainQ8(txGainQ8), .rxGain(rxGain),
  .thermalPending(thermalPending), .thermalIntEn(thermalIntEn),
  .intN(intN)
);

// *** sim/afecp_ctrl_model.sv ***
// Controller model: serial register writer and centred PWM pair
module afecp_ctrl_model #(
  parameter int PWM_PERIOD = 12
) (
  input wire logic clk,
  input wire logic pwmRun,
  input wire logic holdOff,
  output logic sclk,
  output logic csN,
  output logic mosi,
  output logic dacModeSel,
  output logic shutdownPin,
  output logic pwmHigh,
  output logic pwmLow
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  assign dacModeSel = 1'b0;
  assign shutdownPin = holdOff;
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    mosi = 1'b0;
    pwmHigh = 1'b0;
    pwmLow = 1'b0;
  end
  // Same period, two thirds and one third high, both centred
  always @(posedge clk) begin
    cnt <= (cnt == PWM_PERIOD - 1) ? 0 : cnt + 1;
    pwmHigh <= pwmRun && cnt >= PWM_PERIOD / 6 && cnt < PWM_PERIOD * 5 / 6;
    pwmLow <= pwmRun && cnt >= PWM_PERIOD / 3 && cnt < PWM_PERIOD * 2 / 3;
  end
  // One 16-bit frame, MSB first, slow edges for the pin synchronisers
  task automatic send(input logic [15:0] frame);
    @(posedge clk) #1 csN = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi = frame[i];
      repeat (4) @(posedge clk);
      #1 sclk = 1'b1;
      repeat (4) @(posedge clk);
      #1 sclk = 1'b0;
    end
    repeat (4) @(posedge clk);
    #1 csN = 1'b1;
    mosi = ~mosi;
    repeat (8) @(posedge clk);
    // Return off the clock edge so callers never race the design
    #1;
  endtask
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the front-end core
`include "afecp_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, nrst, sclk, csN, mosi, dacModeSel, shutdownPin;
  logic pwmHigh, pwmLow, thermalOverload, pwmRun, holdOff;
  logic [1:0] txSum, biasOn;
  logic txPathOn, paOn, dacOn, zeroCrossOn, thermalPending, thermalIntEn;
  logic intN;
  afecp_pkg::afecp_band_t bandSelect;
  afecp_pkg::afecp_txg_t txGain;
  logic [8:0] txGainQ8;
  logic [3:0] rxGain;
  logic [15:0] seen;
  logic [8:0] q8 [4] = '{9'h040, 9'h080, 9'h0b5, 9'h100};
  logic [7:0] modes [4] = '{8'h03, 8'h07, 8'h02, 8'h01};
  int errCount = 0;
  int numChecks = 0;
  afecp_ctrl_model afecp_ctrl_model_inst (.clk(clk), .pwmRun(pwmRun),
    .holdOff(holdOff), .sclk(sclk), .csN(csN), .mosi(mosi),
    .dacModeSel(dacModeSel), .shutdownPin(shutdownPin),
    .pwmHigh(pwmHigh), .pwmLow(pwmLow));
  afecp_core afecp_core_inst (.clk(clk), .nrst(nrst), .sclk(sclk),
    .csN(csN), .mosi(mosi), .dacModeSel(dacModeSel),
    .shutdownPin(shutdownPin), .pwmHigh(pwmHigh), .pwmLow(pwmLow),
    .thermalOverload(thermalOverload), .txSum(txSum),
    .txPathOn(txPathOn), .paOn(paOn), .dacOn(dacOn), .biasOn(biasOn),
    .zeroCrossOn(zeroCrossOn), .bandSelect(bandSelect), .txGain(txGain),
    .txGainQ8(txGainQ8), .rxGain(rxGain), .thermalPending(thermalPending),
    .thermalIntEn(thermalIntEn), .intN(intN));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    numChecks++;
    if (got !== exp) begin
      errCount++;
      $display("ERROR at %0t: got 0x%0h expected 0x%0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    afecp_ctrl_model_inst.send({1'b0, a, d});
  endtask
  // Collects which sum values appear over two PWM periods
  task automatic sumSeen;
    seen = 16'h0000;
    repeat (24) begin
      @(posedge clk) #1;
      seen[txSum] = 1'b1;
    end
  endtask
  task automatic t_reset;
    chk({txPathOn, paOn, dacOn, biasOn, zeroCrossOn, rxGain}, 16'h0000);
    chk({intN, thermalPending, thermalIntEn, bandSelect, txGain}, 16'h0020);
    chk(txGainQ8, 16'h0040);
  endtask
  task automatic t_setup;
    wr(`AFECP_ADDR_RESET, 8'h14);
    wr(`AFECP_ADDR_BIAS_ZC_ENABLE_REG, 8'h03);
    chk({zeroCrossOn, biasOn}, 16'h0003);
    wr(`AFECP_ADDR_BAND_CONTROL_REG, 8'h01);
    chk(bandSelect, 16'h0001);
    wr(`AFECP_ADDR_BAND_CONTROL_REG, 8'h00);
    chk(bandSelect, 16'h0000);
    wr(`AFECP_ADDR_INTERRUPT_CONTROL_REG, 8'h00);
    wr(`AFECP_ADDR_INTERRUPT_CONTROL_REG, 8'h01);
    chk(thermalIntEn, 16'h0001);
    wr(`AFECP_ADDR_BIAS_ZC_ENABLE_REG, 8'h07);
    chk({zeroCrossOn, biasOn}, 16'h0007);
  endtask
  task automatic t_gain;
    for (int g = 0; g < 4; g++) begin
      wr(`AFECP_ADDR_GAIN, {2'b00, 4'(g * 5), 2'(g)});
      chk(txGain, 16'(g));
      chk(txGainQ8, q8[g]);
      chk(rxGain, 16'(g * 5));
    end
  endtask
  task automatic t_therm;
    @(posedge clk) #1 thermalOverload = 1'b1;
    repeat (4) @(posedge clk);
    #1 thermalOverload = 1'b0;
    repeat (4) @(posedge clk);
    chk({thermalPending, intN}, 16'h0002);
    wr(`AFECP_ADDR_INTERRUPT_CONTROL_REG, 8'h01);
    chk({thermalPending, intN}, 16'h0001);
  endtask
  task automatic t_pwm;
    pwmRun = 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr(`AFECP_ADDR_ENABLE1, modes[m]);
      chk({dacOn, txPathOn, paOn}, modes[m]);
      sumSeen;
      chk(seen, (m == 0) ? 16'h0007 : 16'h0001);
    end
    wr(`AFECP_ADDR_ENABLE1, 8'h03);
    holdOff = 1'b1;
    repeat (6) @(posedge clk);
    sumSeen;
    chk(seen, 16'h0001);
    holdOff = 1'b0;
  endtask
  task automatic t_soft;
    wr(`AFECP_ADDR_RESET, 8'h15);
    afecp_ctrl_model_inst.send({1'b1, `AFECP_ADDR_GAIN, 8'h00});
    chk({txGain, rxGain}, 16'h003f);
    wr(`AFECP_ADDR_RESET, 8'h14);
    repeat (2) @(posedge clk);
    chk({txPathOn, paOn, biasOn, zeroCrossOn, rxGain, txGain}, 16'h0000);
    chk({intN, thermalIntEn, bandSelect, txGainQ8}, 16'h0840);
  endtask
  task automatic conclude;
    if (errCount == 0 && numChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (50000) @(posedge clk);
    errCount++;
    conclude;
  end
  initial begin
    nrst = 1'b0;
    thermalOverload = 1'b0;
    pwmRun = 1'b0;
    holdOff = 1'b0;
    repeat (16) @(posedge clk);
    #1 nrst = 1'b1;
    @(posedge clk) #1;
    t_reset;
    t_setup;
    t_gain;
    t_therm;
    t_pwm;
    t_soft;
    conclude;
  end
endmodule
